/* design/cdt_consts.vh */
// constants of the cascadable down-timer pair
// assumes inclusion by the timer pair top module only
`ifndef CDT_CONSTS_VH
`define CDT_CONSTS_VH
// apb word offsets
`define CDT_ADDR_W 8
`define CDT_OFF_CTRL0 8'h00
`define CDT_OFF_CTRL1 8'h04
`define CDT_OFF_CNT0 8'h08
`define CDT_OFF_CNT1 8'h0C
`define CDT_OFF_STAT 8'h10
`define CDT_OFF_CLR 8'h14
`define CDT_OFF_IEN 8'h18
// control field positions
`define CDT_CTRL_W 7
`define CDT_B_START 0
`define CDT_B_MODE_LO 1
`define CDT_B_MODE_HI 2
`define CDT_B_PULSE 3
`define CDT_B_TRIGSEL 4
`define CDT_B_EDGE 5
`define CDT_B_CASC 6
// channel modes
`define CDT_MODE_TIMER 2'h0
`define CDT_MODE_EVENT 2'h1
`define CDT_MODE_ONESHOT 2'h2
// widths and reset values
`define CDT_CNT_W 16
`define CDT_CTRL_RST 7'h00
`define CDT_CNT_RST 16'h0000
`define CDT_STAT_RST 2'h0
`define CDT_IEN_RST 2'h0
`endif

/* design/cdt_timer_pair.v */
// two 16-bit down-counting timer channels behind apb, channel 1 cascadable from channel 0
// assumes trigger inputs synchronous to clk, single clock domain
`timescale 1ns/100ps
`default_nettype none
`include "cdt_consts.vh"

module cdt_timer_pair #(
    parameter CNT_W = `CDT_CNT_W
) (
    input wire clk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`CDT_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq,
    input wire chan0TriggerInput,
    input wire chan1TriggerInput,
    input wire sharedPortBit0,
    input wire sharedPortBit1,
    output reg chan0PulseOutput,
    output reg chan0PulseOutEnN,
    output reg chan1PulseOutput,
    output reg chan1PulseOutEnN
);

    localparam CW = `CDT_CTRL_W;

    reg [2*CW-1:0] ctrlAll;
    reg [2*CNT_W-1:0] cntAll;
    reg [2*CNT_W-1:0] reloadAll;
    reg [1:0] active;
    reg [1:0] trigPrev;
    reg [1:0] startPrev;
    reg [1:0] pulseLvl;
    reg [1:0] status;
    reg [1:0] ien;

    reg [1:0] tick;
    reg [1:0] uf;
    reg [1:0] trig;
    reg [1:0] edgeHit;
    reg [1:0] wrCnt;
    reg [1:0] clrBits;
    reg [1:0] next_status;
    reg [1:0] next_pulse;
    reg [1:0] next_active;
    reg [2*CNT_W-1:0] next_cnt;
    reg [31:0] rdMux;
    reg rdHit;
    reg src;
    reg [CW-1:0] c;
    reg [CNT_W-1:0] cv;
    integer i;

    wire wrEn;
    wire setup;
    wire [1:0] trigIn;
    wire [1:0] portIn;

    assign wrEn = psel & penable & pready & pwrite;
    assign setup = psel & ~penable;
    assign trigIn = {chan1TriggerInput, chan0TriggerInput};
    assign portIn = {sharedPortBit1, sharedPortBit0};

    function [1:0] modeOf;
        input [CW-1:0] cf;
        begin
            modeOf = cf[`CDT_B_MODE_HI:`CDT_B_MODE_LO];
        end
    endfunction

    function isOneShot;
        input [CW-1:0] cf;
        begin
            isOneShot = (modeOf(cf) == `CDT_MODE_ONESHOT);
        end
    endfunction

    function addrIs;
        input [`CDT_ADDR_W-1:0] a;
        input [`CDT_ADDR_W-1:0] off;
        begin
            addrIs = (a == off);
        end
    endfunction

    // channel event logic
    always @* begin
        tick = 2'b00;
        uf = 2'b00;
        trig = 2'b00;
        edgeHit = 2'b00;
        next_pulse = pulseLvl;
        next_active = active;
        next_cnt = cntAll;
        src = 1'b0;
        c = {CW{1'b0}};
        cv = {CNT_W{1'b0}};
        wrCnt[0] = wrEn & addrIs(paddr, `CDT_OFF_CNT0);
        wrCnt[1] = wrEn & addrIs(paddr, `CDT_OFF_CNT1);
        for (i = 0; i < 2; i = i + 1) begin
            c = ctrlAll[i*CW +: CW];
            cv = cntAll[i*CNT_W +: CNT_W];
            if (c[`CDT_B_EDGE])
                edgeHit[i] = trigIn[i] & ~trigPrev[i];
            else
                edgeHit[i] = ~trigIn[i] & trigPrev[i];
            // cascade source is channel 0 underflow
            if (i == 1 && c[`CDT_B_CASC])
                src = uf[0];
            else
                src = edgeHit[i];
            case (modeOf(c))
                `CDT_MODE_TIMER: begin
                    tick[i] = c[`CDT_B_START];
                end
                `CDT_MODE_EVENT: begin
                    tick[i] = c[`CDT_B_START] & src;
                end
                `CDT_MODE_ONESHOT: begin
                    tick[i] = active[i];
                end
                default: begin
                    tick[i] = c[`CDT_B_START];
                end
            endcase
            if (isOneShot(c))
                uf[i] = tick[i] & (cv <= {{(CNT_W-1){1'b0}}, 1'b1});
            else
                uf[i] = tick[i] & (cv == {CNT_W{1'b0}});
            if (c[`CDT_B_TRIGSEL] | (i == 1 && c[`CDT_B_CASC]))
                trig[i] = c[`CDT_B_START] & ~active[i] & src;
            else
                trig[i] = c[`CDT_B_START] & ~startPrev[i];
            if (~isOneShot(c))
                trig[i] = 1'b0;
            // write to stopped channel loads counter
            if (wrCnt[i] & ~c[`CDT_B_START])
                next_cnt[i*CNT_W +: CNT_W] = pwdata[CNT_W-1:0];
            else if (uf[i])
                next_cnt[i*CNT_W +: CNT_W] = reloadAll[i*CNT_W +: CNT_W];
            else if (tick[i])
                next_cnt[i*CNT_W +: CNT_W] = cv - {{(CNT_W-1){1'b0}}, 1'b1};
            if (~c[`CDT_B_START] | ~isOneShot(c) | uf[i])
                next_active[i] = 1'b0;
            else if (trig[i])
                next_active[i] = 1'b1;
            if (~c[`CDT_B_PULSE])
                next_pulse[i] = 1'b0;
            else if (isOneShot(c)) begin
                if (trig[i])
                    next_pulse[i] = 1'b1;
                else if (uf[i] | ~active[i])
                    next_pulse[i] = 1'b0;
            end
            else if (uf[i])
                next_pulse[i] = ~pulseLvl[i];
        end
    end

    // status set and clear
    always @* begin
        clrBits = 2'b00;
        if (wrEn & addrIs(paddr, `CDT_OFF_CLR))
            clrBits = pwdata[1:0];
        next_status = (status & ~clrBits) | uf;
    end

    // read mux
    always @* begin
        rdMux = 32'h00000000;
        rdHit = 1'b1;
        case (paddr)
            `CDT_OFF_CTRL0: rdMux[CW-1:0] = ctrlAll[CW-1:0];
            `CDT_OFF_CTRL1: rdMux[CW-1:0] = ctrlAll[2*CW-1:CW];
            `CDT_OFF_CNT0: rdMux[CNT_W-1:0] = cntAll[CNT_W-1:0];
            `CDT_OFF_CNT1: rdMux[CNT_W-1:0] = cntAll[2*CNT_W-1:CNT_W];
            `CDT_OFF_STAT: rdMux[5:0] = {active, portIn, status};
            `CDT_OFF_CLR: rdMux = 32'h00000000;
            `CDT_OFF_IEN: rdMux[1:0] = ien;
            default: rdHit = 1'b0;
        endcase
    end

    // apb slave
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~rdHit;
            if (setup & ~pwrite)
                prdata <= rdMux;
        end
    end

    // software registers
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrlAll <= {`CDT_CTRL_RST, `CDT_CTRL_RST};
            reloadAll <= {`CDT_CNT_RST, `CDT_CNT_RST};
            ien <= `CDT_IEN_RST;
        end else begin
            if (wrEn & addrIs(paddr, `CDT_OFF_CTRL0))
                ctrlAll[CW-1:0] <= pwdata[CW-1:0];
            if (wrEn & addrIs(paddr, `CDT_OFF_CTRL1))
                ctrlAll[2*CW-1:CW] <= pwdata[CW-1:0];
            if (wrCnt[0])
                reloadAll[CNT_W-1:0] <= pwdata[CNT_W-1:0];
            if (wrCnt[1])
                reloadAll[2*CNT_W-1:CNT_W] <= pwdata[CNT_W-1:0];
            if (wrEn & addrIs(paddr, `CDT_OFF_IEN))
                ien <= pwdata[1:0];
        end
    end

    // counter state
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cntAll <= {`CDT_CNT_RST, `CDT_CNT_RST};
            active <= 2'b00;
            // trigger pins idle high
            trigPrev <= 2'b11;
            startPrev <= 2'b00;
            status <= `CDT_STAT_RST;
            pulseLvl <= 2'b00;
            irq <= 1'b0;
        end else begin
            cntAll <= next_cnt;
            active <= next_active;
            trigPrev <= trigIn;
            startPrev <= {ctrlAll[CW+`CDT_B_START],
                          ctrlAll[`CDT_B_START]};
            status <= next_status;
            pulseLvl <= next_pulse;
            irq <= |(next_status & ien);
        end
    end

    // pin drivers
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chan0PulseOutput <= 1'b0;
            chan1PulseOutput <= 1'b0;
            chan0PulseOutEnN <= 1'b1;
            chan1PulseOutEnN <= 1'b1;
        end else begin
            chan0PulseOutput <= next_pulse[0];
            chan1PulseOutput <= next_pulse[1];
            chan0PulseOutEnN <= ~ctrlAll[`CDT_B_PULSE];
            chan1PulseOutEnN <= ~ctrlAll[CW+`CDT_B_PULSE];
        end
    end

endmodule // cdt_timer_pair

`default_nettype wire

/* dv/cdt_props.sv */
// assertions on the apb and pin ports of the timer pair
// assumes one clock domain with nrst asynchronous active low
`timescale 1ns/100ps
`default_nettype none
module cdt_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic chan0PulseOutput,
    input wire logic chan0PulseOutEnN,
    input wire logic chan1PulseOutput,
    input wire logic chan1PulseOutEnN
);
    wire logic setupNow = psel && !penable;
    wire logic wrNow = psel && penable && pwrite;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence setupPh;
        setupNow;
    endsequence
    sequence rdyPulse;
        pready ##1 !pready;
    endsequence
    setup_gets_ready_a: assert property (setupPh |=> rdyPulse)
        else $error("no single ready cycle after setup");
    ready_needs_setup_a: assert property (pready |-> $past(setupNow))
        else $error("ready without a setup cycle");
    unmapped_err_a: assert property (pready && paddr > 8'h18 |-> pslverr)
        else $error("unmapped access without error");
    mapped_ok_a: assert property (pready && paddr <= 8'h18
        && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on a mapped register");
    err_reads_zero_a: assert property (pready && pslverr && !pwrite
        |-> prdata == 32'h0)
        else $error("refused read returned data");
    ch0_parked_low_a: assert property (
        chan0PulseOutEnN |-> !chan0PulseOutput)
        else $error("released pin 0 still driven high");
    ch1_parked_low_a: assert property (
        chan1PulseOutEnN |-> !chan1PulseOutput)
        else $error("released pin 1 still driven high");
    release_by_write_a: assert property (
        $changed(chan0PulseOutEnN) |-> $past(wrNow) || $past(wrNow, 2))
        else $error("pin 0 enable moved without a write");
endmodule // cdt_props
`default_nettype wire

/* dv/cdt_pin_model.sv */
// pin model: trigger source and pulled-up shared port pins
// assumes the bench raises pulseReq for one clk per trigger
`timescale 1ns/100ps
`default_nettype none
module cdt_pin_model (
    input wire logic clk,
    input wire logic [1:0] pulseReq,
    input wire logic [1:0] drv,
    input wire logic [1:0] enN,
    output wire logic [1:0] trig,
    output wire logic [1:0] portBit
);
    logic [1:0] low1 = 2'h0;
    logic [1:0] low2 = 2'h0;
    always @(posedge clk) begin
        low1 <= pulseReq;
        low2 <= low1;
    end
    assign trig = ~(low1 | low2);
    // pull-up holds a released pin high
    assign portBit = enN | drv;
endmodule // cdt_pin_model
`default_nettype wire

/* dv/cdt_timer_pair_tb_top.sv */
// bench of the timer pair: apb tasks and a read scoreboard
// assumes the pin model on trigger and port pins
`timescale 1ns/100ps
`default_nettype none
module cdt_timer_pair_tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] req = 2'h0;
    logic pv;
    logic [63:0] nt;
    logic [63:0] notes[$];
    wire logic [31:0] prdata;
    wire logic pready, pslverr, irq;
    wire logic [1:0] trig, port, drv, enN;
    int n_mismatch = 0, checked = 0, cyc = 0, seed = 43, n, m, w, t;
    always #2.5 clk = ~clk;
    cdt_timer_pair i_dut (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .chan0TriggerInput(trig[0]),
        .chan1TriggerInput(trig[1]), .sharedPortBit0(port[0]),
        .sharedPortBit1(port[1]), .chan0PulseOutput(drv[0]),
        .chan0PulseOutEnN(enN[0]), .chan1PulseOutput(drv[1]),
        .chan1PulseOutEnN(enN[1]));
    cdt_pin_model u_pins (.clk(clk), .pulseReq(req), .drv(drv),
        .enN(enN), .trig(trig), .portBit(port));
    task automatic check(input string nm, input [31:0] s, input [31:0] e);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic tally_and_finish;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic apb(input [7:0] a, input w, input [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input [7:0] a, input [31:0] k, input [31:0] e);
        notes.push_back({k, e & k});
        apb(a, 1'b0, 32'h0);
    endtask
    task automatic fire;
        req <= 2'h1;
        @(posedge clk) req <= 2'h0;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish;
        end
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            nt = notes.pop_front();
            check("prdata", prdata & nt[63:32], nt[31:0]);
        end
    end
    initial begin
        wt(5);
        nrst <= 1'b1;
        n = 6 + {$random(seed)} % 7;
        m = 2 + {$random(seed)} % 4;
        rd(8'h00, 32'hFF, 32'h0);
        rd(8'h10, 32'h3F, 32'hC);
        rd(8'h1C, 32'hFFFFFFFF, 32'h0);
        apb(8'h1C, 1'b1, 32'h1);
        apb(8'h08, 1'b1, n);
        apb(8'h00, 1'b1, 32'h1);
        wt(n + 4);
        rd(8'h10, 32'h3, 32'h1);
        check("irq", irq, 32'h0);
        apb(8'h14, 1'b1, 32'h1);
        wt(n + 4);
        rd(8'h10, 32'h1, 32'h1);
        apb(8'h18, 1'b1, 32'h1);
        wt(1);
        check("irq", irq, 32'h1);
        apb(8'h18, 1'b1, 32'h0);
        wt(1);
        check("irq", irq, 32'h0);
        apb(8'h00, 1'b1, 32'h0);
        apb(8'h14, 1'b1, 32'h3);
        rd(8'h10, 32'h3, 32'h0);
        apb(8'h08, 1'b1, n);
        apb(8'h00, 1'b1, 32'h9);
        wt(1);
        check("enN", enN[0], 32'h0);
        pv = drv[0];
        t = 0;
        for (w = 0; w < 4 * n + 4; w++) begin
            @(posedge clk);
            t += (drv[0] !== pv);
            pv = drv[0];
        end
        check("toggles", t, 32'h4);
        apb(8'h00, 1'b1, 32'h0);
        wt(1);
        check("enN", enN[0], 32'h1);
        rd(8'h10, 32'h4, 32'h4);
        apb(8'h08, 1'b1, 32'h0);
        apb(8'h00, 1'b1, 32'h3);
        apb(8'h14, 1'b1, 32'h3);
        fire;
        wt(6);
        rd(8'h10, 32'h1, 32'h1);
        apb(8'h00, 1'b1, 32'h0);
        apb(8'h08, 1'b1, n);
        apb(8'h0C, 1'b1, 32'h1);
        apb(8'h14, 1'b1, 32'h3);
        apb(8'h04, 1'b1, 32'h43);
        apb(8'h00, 1'b1, 32'h1);
        wt(n + n / 2);
        rd(8'h10, 32'h2, 32'h0);
        wt(n + 2);
        rd(8'h10, 32'h2, 32'h2);
        apb(8'h04, 1'b1, 32'h0);
        apb(8'h0C, 1'b1, m);
        apb(8'h14, 1'b1, 32'h3);
        apb(8'h04, 1'b1, 32'h4D);
        t = 0;
        while (drv[1] !== 1'b1 && t < 99) begin
            @(posedge clk);
            t++;
        end
        t = 0;
        while (drv[1] === 1'b1 && t < 99) begin
            @(posedge clk);
            t++;
        end
        check("width", t, m);
        rd(8'h10, 32'h2, 32'h2);
        apb(8'h00, 1'b1, 32'h0);
        apb(8'h04, 1'b1, 32'h0);
        apb(8'h08, 1'b1, m);
        apb(8'h14, 1'b1, 32'h3);
        apb(8'h00, 1'b1, 32'h15);
        wt(3 * m + 4);
        rd(8'h10, 32'h1, 32'h0);
        fire;
        wt(m + 6);
        rd(8'h10, 32'h11, 32'h1);
        rd(8'h08, 32'hFFFF, m);
        tally_and_finish;
    end
endmodule // cdt_timer_pair_tb_top
bind cdt_timer_pair cdt_props u_props (.clk(clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan0PulseOutput(chan0PulseOutput),
    .chan0PulseOutEnN(chan0PulseOutEnN),
    .chan1PulseOutput(chan1PulseOutput),
    .chan1PulseOutEnN(chan1PulseOutEnN));
`default_nettype wire
